//--- mstf_frame.sv
// message interrupt frames: register decode and distributor edge outputs
`timescale 1ns/1ns
module mstf_frame
    import mstf_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                bus_valid,
    input  wire logic                bus_write,
    input  wire logic [ADDR_W-1:0]   bus_addr,
    input  wire logic [31:0]         bus_wdata,
    input  wire logic [3:0]          bus_wstrb,
    input  wire logic                bus_secure,
    output logic                     bus_ack,
    output logic [31:0]              bus_rdata,
    output logic [NS_COUNT-1:0]      ns_spi_edge,
    output logic [S_COUNT-1:0]       s_spi_edge
);
    // ========================================================
    // decode
    logic        sel_s;
    logic [11:0] offset;
    logic        access_ok;
    logic        trig_wr;
    logic [9:0]  spi_id;
    logic [10:0] ns_end;
    logic [10:0] s_end;
    logic        ns_hit;
    logic        s_hit;
    logic [9:0]  ns_idx;
    logic [9:0]  s_idx;
    logic [31:0] type_word;
    logic [31:0] ident_word;
    logic [31:0] rdata_next;

    assign sel_s     = bus_addr[FRAME_BIT];
    assign offset    = bus_addr[11:0];
    // secure frame only exists with the option and only for secure requesters
    assign access_ok = sel_s ? (HAS_SECURE && bus_secure) : 1'b1;
    // byte lane 0 holds bits 7:0; halfword must be the low lanes
    assign trig_wr   = bus_valid && bus_write && access_ok && (offset == OFF_TRIG)
                       && ((bus_wstrb == STRB_WORD) || (bus_wstrb == STRB_HALF));
    assign spi_id    = bus_wdata[9:0];
    assign ns_end    = {1'b0, NS_BASE} + 11'(NS_COUNT);
    assign s_end     = {1'b0, S_BASE} + 11'(S_COUNT);
    assign ns_hit    = trig_wr && !sel_s && (spi_id >= NS_BASE)
                       && ({1'b0, spi_id} < ns_end);
    assign s_hit     = trig_wr && sel_s && (spi_id >= S_BASE)
                       && ({1'b0, spi_id} < s_end);
    assign ns_idx    = spi_id - NS_BASE;
    assign s_idx     = spi_id - S_BASE;

    // both frames share the layout, only the allocation differs
    assign type_word  = sel_s ? {6'h00, S_BASE, 6'h00, 10'(S_COUNT)}
                              : {6'h00, NS_BASE, 6'h00, 10'(NS_COUNT)};
    assign ident_word = {PRODUCT_ID, ARCH_VER, REVISION, JEP_CONT, 1'b0, JEP_IDENT};

    always_comb
    begin
        rdata_next = ZERO_WORD;
        // trigger reads and every reserved offset return zero
        if (bus_valid && !bus_write && access_ok)
        begin
            case (offset)
                OFF_TYPE:  rdata_next = type_word;
                OFF_IDENT: rdata_next = ident_word;
                default:   rdata_next = ZERO_WORD;
            endcase
        end
    end

    // ========================================================
    // bus answer: every request completes one cycle later
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            bus_ack   <= 1'b0;
            bus_rdata <= ZERO_WORD;
        end
        else
        begin
            bus_ack   <= bus_valid;
            bus_rdata <= rdata_next;
        end
    end

    // ========================================================
    // one-cycle pulses; the distributor sees each as a rising edge,
    // so those inputs must be set edge-triggered and fed by nothing else
    for (genvar i = 0; i < NS_COUNT; i++)
    begin : g_ns
        always_ff @(posedge clk)
        begin
            if (reset)
                ns_spi_edge[i] <= 1'b0;
            else
                ns_spi_edge[i] <= ns_hit && (ns_idx == 10'(i));
        end
    end

    for (genvar j = 0; j < S_COUNT; j++)
    begin : g_s
        always_ff @(posedge clk)
        begin
            if (reset)
                s_spi_edge[j] <= 1'b0;
            else
                s_spi_edge[j] <= s_hit && (s_idx == 10'(j));
        end
    end

    // ========================================================
    // checks
    ranges_valid_a: assert property (@(posedge clk) disable iff (reset)
        (NS_BASE >= SPI_MIN) && ({1'b0, NS_BASE} + 11'(NS_COUNT) - 11'd1 <= {1'b0, SPI_MAX})
        && (S_BASE >= SPI_MIN) && ({1'b0, S_BASE} + 11'(S_COUNT) - 11'd1 <= {1'b0, SPI_MAX}))
        else $error("interrupt allocation outside legal range");

    ranges_apart_a: assert property (@(posedge clk) disable iff (reset)
        ({1'b0, NS_BASE} >= s_end) || ({1'b0, S_BASE} >= ns_end))
        else $error("secure and non-secure ranges overlap");

    ack_timing_a: assert property (@(posedge clk) disable iff (reset)
        bus_valid |=> bus_ack ##1 (!bus_ack || $past(bus_valid)))
        else $error("ack not one cycle after request");

    ns_trigger_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && bus_write && !sel_s && (offset == OFF_TRIG) && (bus_wstrb == STRB_WORD)
         && (bus_wdata[9:0] == NS_BASE + 10'd3))
        |=> ns_spi_edge[3] && $onehot(ns_spi_edge))
        else $error("valid trigger write gave no edge");

    half_trigger_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && bus_write && !sel_s && (offset == OFF_TRIG) && (bus_wstrb == STRB_HALF)
         && (bus_wdata[9:0] == NS_BASE)) |=> ns_spi_edge[0])
        else $error("halfword trigger write ignored");

    out_range_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && bus_write && ({1'b0, bus_wdata[9:0]} >= ns_end)
         && ({1'b0, bus_wdata[9:0]} >= s_end))
        |=> (ns_spi_edge == '0) && (s_spi_edge == '0))
        else $error("out of range write raised an edge");

    secure_guard_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && sel_s && !bus_secure)
        |=> (s_spi_edge == '0) && (ns_spi_edge == '0) && (bus_rdata == ZERO_WORD))
        else $error("non-secure access reached secure frame");

    type_read_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && !bus_write && !sel_s && (offset == OFF_TYPE))
        |=> (bus_rdata[25:16] == NS_BASE) && (bus_rdata[9:0] == 10'(NS_COUNT))
            && (bus_rdata[31:26] == 6'h00) && (bus_rdata[15:10] == 6'h00))
        else $error("type register contents wrong");

    ident_read_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && !bus_write && access_ok && (offset == OFF_IDENT))
        |=> (bus_rdata[19:16] == ARCH_VER) && !bus_rdata[7] && (bus_rdata[31:20] == PRODUCT_ID))
        else $error("identification register contents wrong");

    reserved_read_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && !bus_write && (offset != OFF_TYPE) && (offset != OFF_IDENT))
        |=> (bus_rdata == ZERO_WORD))
        else $error("reserved offset read nonzero");

    single_pulse_a: assert property (@(posedge clk) disable iff (reset)
        $onehot0({ns_spi_edge, s_spi_edge}) && ((ns_spi_edge != '0 || s_spi_edge != '0)
        -> $past(bus_valid && bus_write)))
        else $error("edge without a trigger write");

    // ========================================================
    // bus answer checks
    ack_only_req_a: assert property (@(posedge clk) disable iff (reset)
        !bus_valid |=> !bus_ack)
        else $error("ack without a request");

    ack_read_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && !bus_write)
        |=> bus_ack)
        else $error("read not acknowledged");

    ack_write_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && bus_write)
        |=> bus_ack && (bus_rdata == ZERO_WORD))
        else $error("write not acknowledged with zero data");

    rdata_idle_a: assert property (@(posedge clk) disable iff (reset)
        !(bus_valid && !bus_write) |=> (bus_rdata == ZERO_WORD))
        else $error("read data not zero outside a read");

    trig_read_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && !bus_write && (offset == OFF_TRIG))
        |=> (bus_rdata == ZERO_WORD))
        else $error("trigger register read nonzero");

    impl_span_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && !bus_write && (offset > OFF_IDENT))
        |=> (bus_rdata == ZERO_WORD))
        else $error("implementation span read nonzero");

    s_type_read_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && !bus_write && sel_s && bus_secure && HAS_SECURE && (offset == OFF_TYPE))
        |=> (bus_rdata[25:16] == S_BASE) && (bus_rdata[9:0] == 10'(S_COUNT)))
        else $error("secure type register contents wrong");

    ident_low_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && !bus_write && access_ok && (offset == OFF_IDENT))
        |=> (bus_rdata[15:12] == REVISION) && (bus_rdata[11:8] == JEP_CONT)
            && (bus_rdata[6:0] == JEP_IDENT))
        else $error("identification revision or implementer wrong");

    s_ident_read_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && !bus_write && sel_s && bus_secure && HAS_SECURE && (offset == OFF_IDENT))
        |=> (bus_rdata[31:20] == PRODUCT_ID) && (bus_rdata[15:12] == REVISION)
            && (bus_rdata[6:0] == JEP_IDENT))
        else $error("secure identification register contents wrong");

    ident_guard_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && !bus_write && !access_ok) |=> (bus_rdata == ZERO_WORD))
        else $error("refused read returned data");

    // ========================================================
    // trigger checks
    base_index_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && bus_write && !sel_s && (offset == OFF_TRIG) && (bus_wstrb == STRB_WORD)
         && (bus_wdata[9:0] == NS_BASE)) |=> ns_spi_edge[0] && (s_spi_edge == '0))
        else $error("base interrupt write gave no edge");

    top_index_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && bus_write && !sel_s && (offset == OFF_TRIG) && (bus_wstrb == STRB_WORD)
         && (bus_wdata[9:0] == NS_BASE + 10'(NS_COUNT - 1)))
        |=> ns_spi_edge[NS_COUNT-1])
        else $error("last interrupt write gave no edge");

    upper_bits_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && bus_write && !sel_s && (offset == OFF_TRIG) && (bus_wstrb == STRB_WORD)
         && (bus_wdata[31:10] != '0) && (bus_wdata[9:0] == NS_BASE + 10'd5))
        |=> ns_spi_edge[5])
        else $error("upper data bits blocked a trigger");

    mid_half_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && bus_write && !sel_s && (offset == OFF_TRIG) && (bus_wstrb == STRB_HALF)
         && (bus_wdata[9:0] == NS_BASE + 10'd16))
        |=> ns_spi_edge[16])
        else $error("halfword trigger write gave no edge");

    ns_sec_req_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && bus_write && !sel_s && bus_secure && (offset == OFF_TRIG)
         && (bus_wstrb == STRB_WORD) && (bus_wdata[9:0] == NS_BASE + 10'd7))
        |=> ns_spi_edge[7])
        else $error("secure requester refused by non-secure frame");

    s_trigger_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && bus_write && sel_s && bus_secure && HAS_SECURE && (offset == OFF_TRIG)
         && (bus_wstrb == STRB_WORD) && (bus_wdata[9:0] == S_BASE + 10'd5))
        |=> s_spi_edge[5] && $onehot(s_spi_edge) && (ns_spi_edge == '0))
        else $error("secure trigger write gave no edge");

    s_half_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && bus_write && sel_s && bus_secure && HAS_SECURE && (offset == OFF_TRIG)
         && (bus_wstrb == STRB_HALF) && (bus_wdata[9:0] == S_BASE + 10'(S_COUNT - 1)))
        |=> s_spi_edge[S_COUNT-1])
        else $error("secure halfword trigger write ignored");

    strobe_refused_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && bus_write && (bus_wstrb != STRB_WORD) && (bus_wstrb != STRB_HALF))
        |=> (ns_spi_edge == '0) && (s_spi_edge == '0))
        else $error("partial strobe write raised an edge");

    wrong_offset_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && bus_write && (offset != OFF_TRIG))
        |=> (ns_spi_edge == '0) && (s_spi_edge == '0))
        else $error("write to other offset raised an edge");

    ns_below_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && !sel_s && (bus_wdata[9:0] < NS_BASE))
        |=> (ns_spi_edge == '0))
        else $error("number below non-secure range raised an edge");

    ns_above_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && !sel_s && ({1'b0, bus_wdata[9:0]} >= ns_end))
        |=> (ns_spi_edge == '0))
        else $error("number above non-secure range raised an edge");

    s_below_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && sel_s && (bus_wdata[9:0] < S_BASE))
        |=> (s_spi_edge == '0))
        else $error("number below secure range raised an edge");

    ns_frame_only_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && !sel_s) |=> (s_spi_edge == '0))
        else $error("non-secure frame raised a secure edge");

    s_frame_only_a: assert property (@(posedge clk) disable iff (reset)
        (bus_valid && sel_s) |=> (ns_spi_edge == '0))
        else $error("secure frame raised a non-secure edge");

    idle_quiet_a: assert property (@(posedge clk) disable iff (reset)
        !(bus_valid && bus_write) |=> (ns_spi_edge == '0) && (s_spi_edge == '0))
        else $error("edge without a write");

    reset_quiet_a: assert property (@(posedge clk)
        reset |=> !bus_ack && (bus_rdata == ZERO_WORD)
            && (ns_spi_edge == '0) && (s_spi_edge == '0))
        else $error("outputs not cleared by reset");
endmodule : mstf_frame

//--- mstf_pkg.sv
// constants, field layout and register map of the message interrupt frames
//
// Operation
// - each frame is 4KB of 32-bit registers
// - non-secure frame always present, takes non-secure accesses
// - secure frame optional, answers secure accesses only
// - type 0x008, trigger 0x040, identification 0xfcc
// - secure frame repeats layout, own trigger
// - all registers accept 32-bit word accesses
// - trigger registers also take low halfword writes
// - little-endian byte lanes on every access
// - type bits 25:16 give base interrupt number
// - assigned interrupt numbers lie within 32 to 1020
// - type bits 9:0 give contiguous interrupt count
// - trigger registers write-only, reads undefined
// - trigger write pulses interrupt numbered by bits 9:0
// - out-of-range number ignored, no event
// - identification bits 31:20 hold product identifier
// - identification bits 19:16 hold version, zero
// - identification bits 15:12 hold component revision
// - identification bits 11:0 hold implementer code
// - drive an edge on matching distributor input
// - secure and non-secure ranges never overlap
// - frame inputs driven only by this logic
package mstf_pkg;
    // ========================================================
    // bus geometry
    localparam int        ADDR_W      = 13;
    localparam int        FRAME_BIT   = 12;
    localparam logic [11:0] OFF_TYPE  = 12'h008;
    localparam logic [11:0] OFF_TRIG  = 12'h040;
    localparam logic [11:0] OFF_IDENT = 12'hfcc;
    localparam logic [3:0]  STRB_WORD = 4'hf;
    localparam logic [3:0]  STRB_HALF = 4'h3;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    // ========================================================
    // interrupt allocation
    localparam bit        HAS_SECURE  = 1'b1;
    localparam int        NS_COUNT    = 32;
    localparam int        S_COUNT     = 16;
    localparam logic [9:0] NS_BASE    = 10'h040;
    localparam logic [9:0] S_BASE     = 10'h080;
    localparam logic [9:0] SPI_MIN    = 10'h020;
    localparam logic [9:0] SPI_MAX    = 10'h3fc;
    // ========================================================
    // identification fields; product, revision and implementer codes are arbitrary
    localparam logic [11:0] PRODUCT_ID = 12'h5a1;
    localparam logic [3:0]  ARCH_VER   = 4'h0;
    localparam logic [3:0]  REVISION   = 4'h1;
    localparam logic [3:0]  JEP_CONT   = 4'h0;
    localparam logic [6:0]  JEP_IDENT  = 7'h2b;
endpackage : mstf_pkg

//--- mstf_dist_model.sv
// model of the distributor inputs fed by the frame edge outputs
`timescale 1ns/1ns
module mstf_dist_model
    import mstf_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic [NS_COUNT-1:0] ns_spi_edge,
    input  wire logic [S_COUNT-1:0]  s_spi_edge,
    output logic      [7:0]          event_count,
    output logic      [9:0]          last_num
);
    // ========================================================
    // edge capture: only rising edges count, so a held line is one event
    logic [NS_COUNT+S_COUNT-1:0] all_w;
    logic [NS_COUNT+S_COUNT-1:0] prev_reg;
    assign all_w = {s_spi_edge, ns_spi_edge};
    always_ff @(posedge clk)
    begin
        prev_reg <= reset ? '0 : all_w;
        if (reset)
        begin
            event_count <= 8'h00;
            last_num    <= 10'h000;
        end
        else
            for (int i = 0; i < NS_COUNT + S_COUNT; i++)
                if (all_w[i] && !prev_reg[i])
                begin
                    event_count <= event_count + 8'h01;
                    last_num    <= (i < NS_COUNT) ? NS_BASE + 10'(i) : S_BASE + 10'(i - NS_COUNT);
                end
    end
endmodule : mstf_dist_model

//--- msi_to_shared_interrupt_frame_tb_top.sv
// self-checking testbench for the message interrupt frames
`timescale 1ns/1ns
module msi_to_shared_interrupt_frame_tb_top;
    import mstf_pkg::*;
    logic clk = 1'b0, reset = 1'b1, bus_valid = 1'b0, bus_write = 1'b0, bus_secure = 1'b0;
    logic [ADDR_W-1:0] bus_addr = '0;
    logic [31:0] bus_wdata = '0, bus_rdata;
    logic [3:0] bus_wstrb = '0;
    logic bus_ack;
    logic [NS_COUNT-1:0] ns_spi_edge;
    logic [S_COUNT-1:0] s_spi_edge;
    logic [7:0] event_count, n_exp = 8'h00;
    logic [9:0] last_num, last_exp = 10'h000;
    int errors = 0, comparisons = 0;
    localparam logic [31:0] T_NS = {6'h0, NS_BASE, 6'h0, 10'(NS_COUNT)};
    localparam logic [31:0] T_S = {6'h0, S_BASE, 6'h0, 10'(S_COUNT)};
    localparam logic [31:0] ID = {PRODUCT_ID, ARCH_VER, REVISION, JEP_CONT, 1'b0, JEP_IDENT};
    mstf_frame dut (.clk(clk), .reset(reset), .bus_valid(bus_valid), .bus_write(bus_write),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wstrb(bus_wstrb),
        .bus_secure(bus_secure), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
        .ns_spi_edge(ns_spi_edge), .s_spi_edge(s_spi_edge));
    mstf_dist_model far (.clk(clk), .reset(reset), .ns_spi_edge(ns_spi_edge),
        .s_spi_edge(s_spi_edge), .event_count(event_count), .last_num(last_num));
    // ========================================================
    // access tasks
    initial forever #20 clk = ~clk;
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task acc(input logic w, input logic [12:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic sec);
        @(posedge clk);
        bus_valid <= 1'b1;
        bus_write <= w;
        bus_addr <= a;
        bus_wdata <= d;
        bus_wstrb <= s;
        bus_secure <= sec;
        @(posedge clk);
        bus_valid <= 1'b0;
        #1;
        check("ack", {31'h0, bus_ack}, 32'h1);
    endtask : acc
    task rd(input logic [12:0] a, input logic sec, input logic [31:0] exp);
        acc(1'b0, a, 32'h0, STRB_WORD, sec);
        check("rdata", bus_rdata, exp);
    endtask : rd
    // hit says whether an event is due; the extra edge lets the model see the pulse
    task wr(input logic [12:0] a, input logic [31:0] d, input logic [3:0] s, input logic sec,
        input logic hit);
        acc(1'b1, a, d, s, sec);
        @(posedge clk);
        #1;
        if (hit)
        begin
            n_exp = n_exp + 8'h01;
            last_exp = d[9:0];
        end
        check("events", {24'h0, event_count}, {24'h0, n_exp});
        check("number", {22'h0, last_num}, {22'h0, last_exp});
    endtask : wr
    task test_done;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done
    // ========================================================
    // watchdog: the sequence needs about 80 cycles
    initial
    begin
        #200000;
        errors++;
        test_done;
    end
    initial
    begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rd(13'h0008, 1'b0, T_NS);
        rd(13'h1008, 1'b1, T_S);
        rd(13'h1008, 1'b0, 32'h0);
        rd(13'h0fcc, 1'b0, ID);
        rd(13'h1fcc, 1'b1, ID);
        rd(13'h0008, 1'b1, T_NS);
        rd(13'h0040, 1'b0, 32'h0);
        rd(13'h0000, 1'b0, 32'h0);
        rd(13'h0fd0, 1'b0, 32'h0);
        wr(13'h0040, 32'h00000040, STRB_WORD, 1'b0, 1'b1);
        wr(13'h0040, 32'h0000005f, STRB_WORD, 1'b0, 1'b1);
        wr(13'h0040, 32'h00000060, STRB_WORD, 1'b0, 1'b0);
        wr(13'h0040, 32'h0000003f, STRB_WORD, 1'b0, 1'b0);
        wr(13'h0040, 32'h00000050, STRB_HALF, 1'b0, 1'b1);
        wr(13'h0040, 32'h00000043, STRB_WORD, 1'b0, 1'b1);
        wr(13'h0040, 32'h00000040, STRB_HALF, 1'b0, 1'b1);
        wr(13'h0040, 32'h00000047, STRB_WORD, 1'b1, 1'b1);
        wr(13'h0040, 32'h00000051, 4'h1, 1'b0, 1'b0);
        wr(13'h0040, 32'hfffffc45, STRB_WORD, 1'b0, 1'b1);
        wr(13'h1040, 32'h00000085, STRB_WORD, 1'b1, 1'b1);
        wr(13'h1040, 32'h0000008f, STRB_HALF, 1'b1, 1'b1);
        wr(13'h1040, 32'h00000090, STRB_WORD, 1'b1, 1'b0);
        wr(13'h1040, 32'h00000086, STRB_WORD, 1'b0, 1'b0);
        wr(13'h0040, 32'h00000085, STRB_WORD, 1'b0, 1'b0);
        wr(13'h1040, 32'h00000041, STRB_WORD, 1'b1, 1'b0);
        wr(13'h0044, 32'h00000041, STRB_WORD, 1'b0, 1'b0);
        wr(13'h0008, 32'h00000042, STRB_WORD, 1'b0, 1'b0);
        rd(13'h0008, 1'b0, T_NS);
        test_done;
    end
endmodule : msi_to_shared_interrupt_frame_tb_top
